// [hw/psrv_map.vh]
// Register offsets, field positions, codes and reset values of the routing block
`ifndef PSRV_MAP_VH
`define PSRV_MAP_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PSRV_IDX_VDIR 6'h00
`define PSRV_IDX_VOUT 6'h01
`define PSRV_IDX_VIN 6'h02
`define PSRV_IDX_VFLAGS 6'h03
`define PSRV_IDX_ROUTE 6'h05
`define PSRV_IDX_EVSEL 6'h06

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PSRV_CS_LSB 0
`define PSRV_CS_MSB 1
`define PSRV_ADR_LSB 2
`define PSRV_ADR_MSB 3
`define PSRV_EV_MSB 2
`define PSRV_FLAG_MSB 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PSRV_RST_BYTE 8'h00
`define PSRV_RST_ROUTE 4'h0
`define PSRV_RST_EVSEL 3'h0
`define PSRV_RST_FLAGS 2'h0

// ----------------------------------------------------------------
// Address route codes
// ----------------------------------------------------------------
`define PSRV_ADR_F_FULL 2'h0
`define PSRV_ADR_E_FULL 2'h1
`define PSRV_ADR_F_HALF 2'h2
`define PSRV_ADR_E_HALF 2'h3

// ----------------------------------------------------------------
// Chip select route codes and physical port numbers
// ----------------------------------------------------------------
`define PSRV_CS_H 2'h0
`define PSRV_CS_L 2'h1
`define PSRV_CS_F 2'h2
`define PSRV_CS_E 2'h3
`define PSRV_PORT_E 4'h4
`define PSRV_PORT_F 4'h5
`define PSRV_PORT_H 4'h7
`define PSRV_PORT_L 4'ha

// ----------------------------------------------------------------
// Memory type codes of the external bus
// ----------------------------------------------------------------
`define PSRV_MEM_SDRAM 2'h0
`define PSRV_MEM_SRAM 2'h1
`define PSRV_MEM_SRAM_LATCHLESS 2'h2

`endif

// [hw/psrv_top.v]
// Pin routing of the external bus and event output, plus a virtual port window
`timescale 1ns/1ps
`default_nettype none
`include "psrv_map.vh"

module psrv_top #(
    parameter HAS_ADDR_ROUTE = 1
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [3:0] vport_map,
    input wire ebi_four_port,
    input wire [1:0] ebi_mem_type,
    input wire [23:8] ebi_addr,
    input wire [3:0] ebi_cs,
    input wire [7:0] event_channels,
    output reg event_pin_out,
    input wire [31:0] irq_sense_event,
    input wire [127:0] pin_in,
    output reg [127:0] pin_out,
    output reg [127:0] pin_oe_n
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function [7:0] byte_of;
        input [127:0] flat;
        input [3:0] idx;
        begin
            byte_of = flat[idx * 8 +: 8];
        end
    endfunction

    function is_mapped;
        input [5:0] idx;
        begin
            is_mapped = (idx == `PSRV_IDX_VDIR) || (idx == `PSRV_IDX_VOUT) ||
                        (idx == `PSRV_IDX_VIN) || (idx == `PSRV_IDX_VFLAGS) ||
                        (idx == `PSRV_IDX_ROUTE) || (idx == `PSRV_IDX_EVSEL);
        end
    endfunction

    function [7:0] route_byte;
        input [1:0] mem;
        input half;
        input [23:8] a;
        begin
            route_byte = 8'h00;
            if (half) begin
                case (mem)
                    `PSRV_MEM_SDRAM: route_byte = {a[11:8], 4'h0};
                    `PSRV_MEM_SRAM: route_byte = {a[19:16], 4'h0};
                    default: route_byte = 8'h00;
                endcase
            end else begin
                case (mem)
                    `PSRV_MEM_SDRAM: route_byte = {4'h0, a[11:8]};
                    `PSRV_MEM_SRAM: route_byte = a[23:16];
                    `PSRV_MEM_SRAM_LATCHLESS: route_byte = a[15:8];
                    default: route_byte = 8'h00;
                endcase
            end
        end
    endfunction

    // Latchless variants have no upper address on a half route, so no pin is taken
    function [7:0] route_mask;
        input [1:0] mem;
        input half;
        begin
            case (mem)
                `PSRV_MEM_SDRAM: route_mask = half ? 8'hf0 : 8'hff;
                `PSRV_MEM_SRAM: route_mask = half ? 8'hf0 : 8'hff;
                `PSRV_MEM_SRAM_LATCHLESS: route_mask = half ? 8'h00 : 8'hff;
                default: route_mask = 8'h00;
            endcase
        end
    endfunction

    function [7:0] overlay;
        input [7:0] base;
        input [7:0] val;
        input [7:0] mask;
        begin
            overlay = (base & ~mask) | (val & mask);
        end
    endfunction

    function [3:0] cs_port_of;
        input [1:0] code;
        begin
            case (code)
                `PSRV_CS_H: cs_port_of = `PSRV_PORT_H;
                `PSRV_CS_L: cs_port_of = `PSRV_PORT_L;
                `PSRV_CS_F: cs_port_of = `PSRV_PORT_F;
                default: cs_port_of = `PSRV_PORT_E;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg [7:0] dir_reg [0:15];
    reg [7:0] out_reg [0:15];
    reg [1:0] flag_reg [0:15];
    reg [3:0] route_reg;
    reg [2:0] evsel_reg;
    reg [127:0] pin_out_next;
    reg [127:0] pin_oe_n_next;
    reg [127:0] dir_flat;
    reg [127:0] out_flat;
    reg [31:0] rdata_next;
    reg [7:0] drive_mask;
    reg [7:0] addr_byte;
    integer i;
    integer p;
    integer q;
    integer r;

    wire [5:0] reg_idx = paddr[7:2];
    wire aligned = (paddr[1:0] == 2'h0);
    wire hit = aligned && is_mapped(reg_idx);
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire wr_en = access && pwrite && hit && pstrb[0];
    wire [1:0] adr_route = route_reg[`PSRV_ADR_MSB:`PSRV_ADR_LSB];
    wire [1:0] cs_route = route_reg[`PSRV_CS_MSB:`PSRV_CS_LSB];

    // Per-register write strobes
    wire wr_vdir = wr_en && (reg_idx == `PSRV_IDX_VDIR);
    wire wr_vout = wr_en && (reg_idx == `PSRV_IDX_VOUT);
    wire wr_flags = wr_en && (reg_idx == `PSRV_IDX_VFLAGS);
    wire wr_route = wr_en && (reg_idx == `PSRV_IDX_ROUTE);
    wire wr_evsel = wr_en && (reg_idx == `PSRV_IDX_EVSEL);
    wire [3:0] cs_port = cs_port_of(cs_route);

    // ----------------------------------------------------------------
    // APB answer
    // ----------------------------------------------------------------
    // no wait
    assign pready = 1'b1;
    assign pslverr = access && !hit;

    always @* begin
        rdata_next = 32'h0000_0000;
        case (reg_idx)
            `PSRV_IDX_VDIR: rdata_next[7:0] = dir_reg[vport_map];
            `PSRV_IDX_VOUT: rdata_next[7:0] = out_reg[vport_map];
            `PSRV_IDX_VIN: rdata_next[7:0] = byte_of(pin_in, vport_map);
            `PSRV_IDX_VFLAGS: rdata_next[`PSRV_FLAG_MSB:0] = flag_reg[vport_map];
            `PSRV_IDX_ROUTE: rdata_next[3:0] = route_reg;
            `PSRV_IDX_EVSEL: rdata_next[`PSRV_EV_MSB:0] = evsel_reg;
            default: rdata_next = 32'h0000_0000;
        endcase
        if (!aligned) begin
            rdata_next = 32'h0000_0000;
        end
    end

    // Captured in the setup cycle so the data stands for the whole access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= rdata_next;
        end
    end

    // ----------------------------------------------------------------
    // Physical port registers behind the window
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < 16; i = i + 1) begin
                dir_reg[i] <= `PSRV_RST_BYTE;
            end
        end else if (wr_vdir) begin
            dir_reg[vport_map] <= pwdata[7:0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (p = 0; p < 16; p = p + 1) begin
                out_reg[p] <= `PSRV_RST_BYTE;
            end
        end else if (wr_vout) begin
            out_reg[vport_map] <= pwdata[7:0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_reg <= `PSRV_RST_ROUTE;
            evsel_reg <= `PSRV_RST_EVSEL;
        end else begin
            if (wr_route) begin
                route_reg <= pwdata[3:0];
            end
            if (wr_evsel) begin
                evsel_reg <= pwdata[`PSRV_EV_MSB:0];
            end
        end
    end

    // Set wins over a same-cycle clear so no sense event is lost
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (q = 0; q < 16; q = q + 1) begin
                flag_reg[q] <= `PSRV_RST_FLAGS;
            end
        end else begin
            for (q = 0; q < 16; q = q + 1) begin
                flag_reg[q] <= (flag_reg[q] &
                    ~({2{wr_flags && (vport_map == q[3:0])}} & pwdata[`PSRV_FLAG_MSB:0])) |
                    irq_sense_event[q * 2 +: 2];
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin routing
    // ----------------------------------------------------------------
    always @* begin
        dir_flat = 128'h0;
        out_flat = 128'h0;
        for (r = 0; r < 16; r = r + 1) begin
            dir_flat[r * 8 +: 8] = dir_reg[r];
            out_flat[r * 8 +: 8] = out_reg[r];
        end
        pin_out_next = out_flat;
        addr_byte = route_byte(ebi_mem_type, adr_route[1], ebi_addr);
        drive_mask = route_mask(ebi_mem_type, adr_route[1]);
        if ((HAS_ADDR_ROUTE != 0) && ebi_four_port) begin
            case (adr_route)
                `PSRV_ADR_F_FULL, `PSRV_ADR_F_HALF: begin
                    pin_out_next[`PSRV_PORT_F * 8 +: 8] =
                        overlay(out_flat[`PSRV_PORT_F * 8 +: 8], addr_byte, drive_mask);
                end
                default: begin
                    pin_out_next[`PSRV_PORT_E * 8 +: 8] =
                        overlay(out_flat[`PSRV_PORT_E * 8 +: 8], addr_byte, drive_mask);
                end
            endcase
        end

        // chip select port; placed last so it wins over address pins
        pin_out_next[cs_port * 8 + 4 +: 4] = ebi_cs;

        pin_oe_n_next = ~dir_flat;
    end

    // ----------------------------------------------------------------
    // Registered pin outputs
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= 128'h0;
        end else begin
            pin_out <= pin_out_next;
        end
    end

    // Pins float until software sets a direction
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_oe_n <= {128{1'b1}};
        end else begin
            pin_oe_n <= pin_oe_n_next;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_pin_out <= 1'b0;
        end else begin
            event_pin_out <= event_channels[evsel_reg];
        end
    end

endmodule
`default_nettype wire

// [bench/psrv_pins.sv]
// Pin partner: each pin shows the block where it drives, else outside level
`timescale 1ns/1ps
`default_nettype none
module psrv_pins (
    input wire logic [127:0] pin_out,
    input wire logic [127:0] pin_oe_n,
    input wire logic [127:0] ext,
    output logic [127:0] pin_in
);
    assign pin_in = (pin_out & ~pin_oe_n) | (ext & pin_oe_n);
endmodule
`default_nettype wire

// [bench/psrv_chk.sv]
// Checker of bus, pin and event timing of the routing block
`timescale 1ns/1ps
`default_nettype none
module psrv_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] vport_map,
    input wire logic [3:0] ebi_cs,
    input wire logic [7:0] event_channels,
    input wire logic event_pin_out,
    input wire logic [127:0] pin_out,
    input wire logic [127:0] pin_oe_n
);
    logic wr, ev_exp;
    logic [1:0] rt_reg, rt_d;
    logic [3:0] cs_d, cs_port;
    logic [2:0] ev_reg;
    assign wr = psel && penable && pwrite && pstrb[0];
    assign cs_port = rt_d[1] ? (rt_d[0] ? 4'h4 : 4'h5) : (rt_d[0] ? 4'ha : 4'h7);
    // Shadows lag one edge, matching the registered pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rt_reg <= 2'h0;
            rt_d <= 2'h0;
            cs_d <= 4'h0;
            ev_reg <= 3'h0;
            ev_exp <= 1'h0;
        end else begin
            if (wr && paddr == 8'h14)
                rt_reg <= pwdata[1:0];
            if (wr && paddr == 8'h18)
                ev_reg <= pwdata[2:0];
            rt_d <= rt_reg;
            cs_d <= ebi_cs;
            ev_exp <= event_channels[ev_reg];
        end
    end
    // ----
    // Checks
    // ----
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ready_always_a: assert property (pready)
        else $error("pready low");
    hole_error_a: assert property (psel && penable && paddr == 8'h10 |-> pslverr)
        else $error("no error on hole");
    error_placed_a: assert property (pslverr |-> psel && penable)
        else $error("stray pslverr");
    read_upper_a: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    cs_route_a: assert property (pin_out[{cs_port, 3'h4} +: 4] == cs_d)
        else $error("chip selects misplaced");
    event_pin_a: assert property (event_pin_out == ev_exp)
        else $error("event pin wrong");
    reset_float_a: assert property ($rose(presetn) |-> &pin_oe_n)
        else $error("pins driven after reset");
    pin_drive_a: assert property (wr && paddr == 8'h00 ##1 !penable && $stable(vport_map)
        ##1 $stable(vport_map) |-> pin_oe_n[{vport_map, 3'h0} +: 8] == ~$past(pwdata[7:0], 2))
        else $error("mapped direction not on pins");
    pin_value_a: assert property (wr && paddr == 8'h04
        && !(vport_map inside {4'h4, 4'h5, 4'h7, 4'ha}) ##1 !penable && $stable(vport_map)
        ##1 $stable(vport_map) |-> pin_out[{vport_map, 3'h0} +: 8] == $past(pwdata[7:0], 2))
        else $error("mapped output not on pins");
endmodule
bind psrv_top psrv_chk psrv_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .vport_map(vport_map),
    .ebi_cs(ebi_cs), .event_channels(event_channels), .event_pin_out(event_pin_out),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n));
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench of the routing block and its pin partner
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ebi_four_port = 0;
    logic [7:0] paddr = 0, event_channels = 0, d, o;
    logic [31:0] pwdata = 0, irq_sense_event = 0, prdata, rd;
    logic [3:0] pstrb = 0, vport_map = 0, ebi_cs = 0, m;
    logic [1:0] ebi_mem_type = 0;
    logic [23:8] ebi_addr = 0;
    logic [127:0] ext = 0, pin_in, pin_out, pin_oe_n;
    logic pready, pslverr, event_pin_out, err;
    integer num_errors = 0, checks_done = 0, seed = 1335, cyc = 0, i, j;
    psrv_top psrv_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .vport_map(vport_map),
        .ebi_four_port(ebi_four_port), .ebi_mem_type(ebi_mem_type), .ebi_addr(ebi_addr),
        .ebi_cs(ebi_cs), .event_channels(event_channels), .event_pin_out(event_pin_out),
        .irq_sense_event(irq_sense_event), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n));
    psrv_pins psrv_pins_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext(ext), .pin_in(pin_in));
    initial begin
        forever #2 pclk = ~pclk;
    end
    // ----
    // Helpers
    // ----
    task automatic conclude();
        if (num_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Generous ceiling: the full sequence needs under 2000 cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors = num_errors + 1;
            conclude();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done = checks_done + 1;
        if (g !== e) begin
            num_errors = num_errors + 1;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
            input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        apb(1'h1, a, v, 4'h1);
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0, 4'h0);
        chk(n, e, rd);
    endtask
    function automatic logic [7:0] adr_exp(input int a, input int t, input logic [23:8] x);
        if (a < 2)
            return t == 0 ? {4'h0, x[11:8]} : t == 1 ? x[23:16] : x[15:8];
        return t == 0 ? {x[11:8], 4'h0} : t == 1 ? {x[19:16], 4'h0} : 8'h00;
    endfunction
    function automatic int cs_port(input int c);
        return c == 0 ? 7 : c == 1 ? 10 : c == 2 ? 5 : 4;
    endfunction
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        for (i = 0; i < 7; i++) begin
            rdc("reset value", 4 * i, 32'h0);
            chk("refusal", i == 4, err);
        end
        for (i = 0; i < 12; i++) begin
            j = $random(seed);
            m = j[3:0] == 4'h7 ? 4'h0 : j[3:0];
            d = j[15:8];
            o = j[23:16];
            vport_map <= m;
            ext <= {$random(seed), $random(seed), $random(seed), $random(seed)};
            wr(8'h00, d);
            wr(8'h04, o);
            wr(8'h08, 32'hff);
            rdc("direction", 8'h00, d);
            rdc("output", 8'h04, o);
            rdc("input", 8'h08, (d & o) | (~d & ext[m * 8 +: 8]));
            irq_sense_event <= 32'h1 << (2 * m + j[24]);
            @(posedge pclk);
            irq_sense_event <= 32'h0;
            rdc("flag set", 8'h0c, 32'h1 << j[24]);
            wr(8'h0c, 32'hfc);
            rdc("flag kept", 8'h0c, 32'h1 << j[24]);
            wr(8'h0c, 32'h03);
            rdc("flag cleared", 8'h0c, 32'h0);
        end
        apb(1'h1, 8'h00, 32'h0, 4'h0);
        rdc("strobe off", 8'h00, d);
        for (i = 0; i < 8; i++) begin
            wr(8'h18, 32'hf8 | i);
            rdc("event select", 8'h18, i);
            event_channels <= $random(seed);
            repeat (3) @(posedge pclk);
            chk("event pin", event_channels[i], event_pin_out);
        end
        for (i = 0; i < 4; i++) begin
            wr(8'h14, 32'hf0 | i);
            rdc("route", 8'h14, i);
            ebi_cs <= $random(seed);
            repeat (3) @(posedge pclk);
            chk("chip selects", ebi_cs, pin_out[cs_port(i) * 8 + 4 +: 4]);
        end
        for (i = 4; i < 6; i++) begin
            vport_map <= i;
            wr(8'h00, 32'hff);
            wr(8'h04, 32'h0);
        end
        ebi_four_port <= 1'h1;
        for (i = 0; i < 12; i++) begin
            ebi_mem_type <= i % 3;
            ebi_addr <= $random(seed);
            wr(8'h14, (i / 3) << 2);
            repeat (3) @(posedge pclk);
            chk("address", adr_exp(i / 3, i % 3, ebi_addr), pin_in[(i / 3) % 2 ? 32 : 40 +: 8]);
        end
        wr(8'h14, 32'h0);
        ebi_mem_type <= 2'h1;
        ebi_addr <= 16'ha5c3;
        ebi_four_port <= 1'h0;
        repeat (3) @(posedge pclk);
        chk("mode off", 32'h0, pin_in[47:40]);
        conclude();
    end
endmodule
`default_nettype wire
